// ===== rtl/kpu_defines.svh
`ifndef KPU_DEFINES_SVH
`define KPU_DEFINES_SVH
// ****************************************
// timing
// ****************************************
`define KPU_CLK_KHZ 25000
`define KPU_TICK_US 30
`define KPU_TICK_CYC ((`KPU_CLK_KHZ * `KPU_TICK_US) / 1000)
`define KPU_STAB_TICKS 11'h001
// ****************************************
// register map
// ****************************************
`define KPU_ADDR_WAIT 32'h0b000192
`define KPU_ADDR_EMPTY_SCAN_REPEATS 32'h0b000194
`define KPU_ADDR_FLAGS 32'h0b000196
`define KPU_ADDR_CTRL 32'h0b0001a0
`define KPU_ADDR_IDLE 32'h0b0001a2
`define KPU_WAIT_W 10
`define KPU_REP_W 6
`define KPU_IDLE_W 5
`define KPU_IDLE_RST 5'h1f
`define KPU_REP_FULL 7'h40
// ****************************************
// field positions
// ****************************************
`define KPU_FLG_KEY 0
`define KPU_FLG_DONE 1
`define KPU_FLG_LOST 2
`define KPU_FLG_PG1 3
`define KPU_FLG_PG2 4
`define KPU_FLG_W 5
`define KPU_CTL_EN 0
`define KPU_CTL_AUTOSCAN 1
`define KPU_CTL_AUTOSTOP 2
`define KPU_CTL_PGSTOP 3
`define KPU_CTL_W 4
`define KPU_COLS 8
`define KPU_LAST_COL 3'h7
`endif

// ===== rtl/kpu_pkg.sv
`default_nettype none
package kpu_pkg;
  typedef enum logic [2:0] {
    kpu_st_stop,
    kpu_st_waitkey,
    kpu_st_drive,
    kpu_st_idle
  } kpu_state_t;
endpackage
`default_nettype wire

// ===== rtl/kpu_aux_if.sv
`timescale 1ns/1ps
`default_nettype none
interface kpu_aux_if;
  logic tick;
  logic [7:0] ret;
  modport tick_src (output tick);
  modport sync_src (output ret);
  modport core (input tick, input ret);
endinterface
`default_nettype wire

// ===== rtl/kpu_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "kpu_defines.svh"
module kpu_tick (
  input wire logic clock,
  input wire logic rst,
  kpu_aux_if.tick_src aux
);
  localparam logic [9:0] TICK_LAST = 10'(`KPU_TICK_CYC - 1);
  logic [9:0] cnt_q;
  logic tick_q;
  wire cnt_wrap = (cnt_q == TICK_LAST);

  // 30 us time base
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_q <= 10'h000;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_wrap ? 10'h000 : cnt_q + 10'h001;
      tick_q <= cnt_wrap;
    end
  end
  assign aux.tick = tick_q;

  property p_tick_gap;
    @(posedge clock) disable iff (rst) tick_q |=> (!tick_q) [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick repeats too soon");
endmodule
`default_nettype wire

// ===== rtl/kpu_sync.sv
`timescale 1ns/1ps
`default_nettype none
module kpu_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] return_line_in,
  kpu_aux_if.sync_src aux
);
  logic [7:0] meta_q;
  logic [7:0] sync_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
    end else begin
      meta_q <= return_line_in;
      sync_q <= meta_q;
    end
  end
  assign aux.ret = sync_q;
endmodule
`default_nettype wire

// ===== rtl/kpu_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "kpu_defines.svh"
module kpu_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic [31:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [7:0] return_line_in,
  output logic [7:0] scan_column_out,
  output logic [7:0] scan_column_oe_n,
  input wire logic dma_page_in,
  input wire logic dma_ack,
  output logic dma_req,
  output logic [63:0] key_data_out
);
  kpu_aux_if aux ();

  kpu_tick u_tick (
    .clock(clock),
    .rst(rst),
    .aux(aux.tick_src)
  );

  kpu_sync u_sync (
    .clock(clock),
    .rst(rst),
    .return_line_in(return_line_in),
    .aux(aux.sync_src)
  );

  // ****************************************
  // registers
  // ****************************************
  logic [`KPU_WAIT_W-1:0] wait_interval_count_q;
  logic [`KPU_REP_W-1:0] empty_scan_repeats_q;
  logic [`KPU_IDLE_W-1:0] idle_count_q;
  logic [`KPU_CTL_W-1:0] ctl_q;
  logic [`KPU_FLG_W-1:0] flags_q;
  logic [`KPU_FLG_W-1:0] flags_d;
  logic [`KPU_FLG_W-1:0] flag_set;
  logic [15:0] rdata_q;

  wire wr_wait = reg_wr && (reg_addr == `KPU_ADDR_WAIT);
  wire wr_rep = reg_wr && (reg_addr == `KPU_ADDR_EMPTY_SCAN_REPEATS);
  wire wr_flags = reg_wr && (reg_addr == `KPU_ADDR_FLAGS);
  wire wr_ctl = reg_wr && (reg_addr == `KPU_ADDR_CTRL);
  wire wr_idle = reg_wr && (reg_addr == `KPU_ADDR_IDLE);

  wire scan_en = ctl_q[`KPU_CTL_EN];
  wire auto_scan = ctl_q[`KPU_CTL_AUTOSCAN];
  wire auto_stop = ctl_q[`KPU_CTL_AUTOSTOP];
  wire page_stop_enable = ctl_q[`KPU_CTL_PGSTOP];

  // ****************************************
  // sequencer
  // ****************************************
  kpu_pkg::kpu_state_t state_q;
  kpu_pkg::kpu_state_t state_d;
  logic [2:0] col_q;
  logic [2:0] col_d;
  logic [10:0] timer_q;
  logic [10:0] timer_d;
  logic [63:0] work_q;
  logic [63:0] key_data_q;
  logic [6:0] empty_cnt_q;
  logic stop_hit_q;
  logic pending_q;
  logic page_sel_q;
  logic dma_req_q;
  logic [7:0] col_out_q;
  logic [7:0] col_oe_n_q;
  logic sample;
  logic done_pulse;
  logic auto_halt;

  wire any_ret = |aux.ret;
  wire timer_expire = (timer_q == 11'h000) || (aux.tick && timer_q == 11'h001);
  wire last_col = (col_q == `KPU_LAST_COL);
  wire [10:0] idle_ticks = 11'(idle_count_q) + 11'h001;
  wire [10:0] gap_ticks = idle_ticks + 11'(wait_interval_count_q);
  wire [6:0] rep_target = (empty_scan_repeats_q == 6'h00) ? `KPU_REP_FULL :
                          7'(empty_scan_repeats_q);
  wire [63:0] work_next = work_q | (64'(aux.ret) << {col_q, 3'h0});
  wire scan_zero = (work_next == 64'h0);
  wire [6:0] empty_next = scan_zero ? empty_cnt_q + 7'h01 : 7'h00;

  always_comb begin
    state_d = state_q;
    col_d = col_q;
    timer_d = timer_q;
    sample = 1'b0;
    auto_halt = 1'b0;
    if (aux.tick && timer_q != 11'h000) begin
      timer_d = timer_q - 11'h001;
    end
    unique case (state_q)
      kpu_pkg::kpu_st_stop: begin
        if (scan_en && auto_scan) begin
          state_d = kpu_pkg::kpu_st_waitkey;
        end else if (scan_en) begin
          state_d = kpu_pkg::kpu_st_drive;
          col_d = 3'h0;
          timer_d = `KPU_STAB_TICKS;
        end
      end
      kpu_pkg::kpu_st_waitkey: begin
        if (any_ret) begin
          state_d = kpu_pkg::kpu_st_drive;
          col_d = 3'h0;
          timer_d = `KPU_STAB_TICKS;
        end
      end
      kpu_pkg::kpu_st_drive: begin
        if (timer_expire) begin
          sample = 1'b1;
          state_d = kpu_pkg::kpu_st_idle;
          timer_d = last_col ? gap_ticks : idle_ticks;
        end
      end
      kpu_pkg::kpu_st_idle: begin
        if (timer_expire && last_col && stop_hit_q) begin
          auto_halt = !auto_scan;
          state_d = auto_scan ? kpu_pkg::kpu_st_waitkey : kpu_pkg::kpu_st_stop;
        end else if (timer_expire) begin
          state_d = kpu_pkg::kpu_st_drive;
          col_d = col_q + 3'h1;
          timer_d = `KPU_STAB_TICKS;
        end
      end
    endcase
    if (!scan_en) begin
      state_d = kpu_pkg::kpu_st_stop;
    end
  end

  assign done_pulse = sample && last_col;

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= kpu_pkg::kpu_st_stop;
      col_q <= 3'h0;
      timer_q <= 11'h000;
    end else begin
      state_q <= state_d;
      col_q <= col_d;
      timer_q <= timer_d;
    end
  end

  // key data collection and empty scan count
  always_ff @(posedge clock) begin
    if (rst) begin
      work_q <= 64'h0;
      key_data_q <= 64'h0;
      empty_cnt_q <= 7'h00;
      stop_hit_q <= 1'b0;
    end else if (done_pulse) begin
      work_q <= 64'h0;
      key_data_q <= work_next;
      empty_cnt_q <= (empty_next >= rep_target) ? 7'h00 : empty_next;
      stop_hit_q <= auto_stop && (empty_next >= rep_target);
    end else if (sample) begin
      work_q <= work_next;
    end else if (state_q == kpu_pkg::kpu_st_stop) begin
      work_q <= 64'h0;
      empty_cnt_q <= 7'h00;
      stop_hit_q <= 1'b0;
    end
  end

  // column drive: waitkey drives all high, drive one column
  wire [7:0] onehot = 8'h01 << col_q;
  wire [7:0] col_out_d = (state_q == kpu_pkg::kpu_st_waitkey) ? 8'hff :
                         (state_q == kpu_pkg::kpu_st_drive) ? onehot : 8'h00;

  always_ff @(posedge clock) begin
    if (rst) begin
      col_out_q <= 8'h00;
      col_oe_n_q <= 8'hff;
    end else begin
      col_out_q <= col_out_d;
      col_oe_n_q <= ~col_out_d;
    end
  end

  // ****************************************
  // dma side
  // ****************************************
  wire page_hit = dma_ack && dma_page_in;
  wire dma_halt = (page_stop_enable && flags_q[`KPU_FLG_PG1]) || flags_q[`KPU_FLG_PG2];

  always_ff @(posedge clock) begin
    if (rst) begin
      pending_q <= 1'b0;
      page_sel_q <= 1'b0;
      dma_req_q <= 1'b0;
    end else begin
      pending_q <= done_pulse || (pending_q && !dma_ack);
      page_sel_q <= page_hit ? !page_sel_q : page_sel_q;
      dma_req_q <= pending_q && !dma_ack && !dma_halt;
    end
  end

  // ****************************************
  // flags, set wins over clear
  // ****************************************
  assign flag_set[`KPU_FLG_KEY] = any_ret && (state_q != kpu_pkg::kpu_st_stop);
  assign flag_set[`KPU_FLG_DONE] = done_pulse;
  assign flag_set[`KPU_FLG_LOST] = done_pulse && pending_q && !dma_ack;
  assign flag_set[`KPU_FLG_PG1] = page_hit && !page_sel_q;
  assign flag_set[`KPU_FLG_PG2] = page_hit && page_sel_q;
  wire [`KPU_FLG_W-1:0] flag_clr = wr_flags ? reg_wdata[`KPU_FLG_W-1:0] : '0;
  assign flags_d = (flags_q & ~flag_clr) | flag_set;

  always_ff @(posedge clock) begin
    if (rst) begin
      wait_interval_count_q <= '0;
      empty_scan_repeats_q <= '0;
      idle_count_q <= `KPU_IDLE_RST;
      ctl_q <= '0;
      flags_q <= '0;
    end else begin
      if (wr_wait) wait_interval_count_q <= reg_wdata[`KPU_WAIT_W-1:0];
      if (wr_rep) empty_scan_repeats_q <= reg_wdata[`KPU_REP_W-1:0];
      if (wr_idle) idle_count_q <= reg_wdata[`KPU_IDLE_W-1:0];
      if (wr_ctl) begin
        ctl_q <= reg_wdata[`KPU_CTL_W-1:0];
      end else if (auto_halt) begin
        ctl_q[`KPU_CTL_EN] <= 1'b0;
      end
      flags_q <= flags_d;
    end
  end

  // ****************************************
  // read path, zero fill above each field except control, which carries state in bits 6:4
  // ****************************************
  wire [15:0] rd_mux =
    (reg_addr == `KPU_ADDR_WAIT) ? 16'(wait_interval_count_q) :
    (reg_addr == `KPU_ADDR_EMPTY_SCAN_REPEATS) ? 16'(empty_scan_repeats_q) :
    (reg_addr == `KPU_ADDR_FLAGS) ? 16'(flags_q) :
    (reg_addr == `KPU_ADDR_CTRL) ? {9'h000, 3'(state_q), ctl_q} :
    (reg_addr == `KPU_ADDR_IDLE) ? 16'(idle_count_q) : 16'h0000;

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  assign reg_rdata = rdata_q;
  assign scan_column_out = col_out_q;
  assign scan_column_oe_n = col_oe_n_q;
  assign dma_req = dma_req_q;
  assign key_data_out = key_data_q;

  // ****************************************
  // checks
  // ****************************************
  property p_gap_load;
    @(posedge clock) disable iff (rst)
      (done_pulse && scan_en) |=> (timer_q == $past(gap_ticks));
  endproperty
  a_gap_load: assert property (p_gap_load) else $error("bad gap after last column");

  property p_w1c;
    @(posedge clock) disable iff (rst)
      (wr_flags && reg_wdata[`KPU_FLG_DONE] && !done_pulse) |=> !flags_q[`KPU_FLG_DONE];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared by one");

  property p_w0_hold;
    @(posedge clock) disable iff (rst)
      (wr_flags && !reg_wdata[`KPU_FLG_LOST] && flags_q[`KPU_FLG_LOST])
      |=> flags_q[`KPU_FLG_LOST];
  endproperty
  a_w0_hold: assert property (p_w0_hold) else $error("flag lost on zero write");

  property p_key_start;
    @(posedge clock) disable iff (rst)
      (state_q == kpu_pkg::kpu_st_waitkey && any_ret && scan_en)
      |=> flags_q[`KPU_FLG_KEY] && state_q == kpu_pkg::kpu_st_drive ##1 col_out_q == 8'h01;
  endproperty
  a_key_start: assert property (p_key_start) else $error("key input did not start scan");

  property p_done;
    @(posedge clock) disable iff (rst) done_pulse |=> flags_q[`KPU_FLG_DONE] && pending_q;
  endproperty
  a_done: assert property (p_done) else $error("scan completion not flagged");

  property p_lost;
    @(posedge clock) disable iff (rst)
      (done_pulse && pending_q && !dma_ack) |=> flags_q[`KPU_FLG_LOST];
  endproperty
  a_lost: assert property (p_lost) else $error("data loss not flagged");

  property p_pg1;
    @(posedge clock) disable iff (rst)
      (page_hit && !page_sel_q) |=> flags_q[`KPU_FLG_PG1] && page_sel_q;
  endproperty
  a_pg1: assert property (p_pg1) else $error("first page boundary missed");

  property p_pg1_halt;
    @(posedge clock) disable iff (rst)
      (flags_q[`KPU_FLG_PG1] && page_stop_enable) |=> !dma_req_q;
  endproperty
  a_pg1_halt: assert property (p_pg1_halt) else $error("request after page one stop");

  property p_pg2_halt;
    @(posedge clock) disable iff (rst) flags_q[`KPU_FLG_PG2] |=> !dma_req_q;
  endproperty
  a_pg2_halt: assert property (p_pg2_halt) else $error("request after page two");

  property p_resv;
    @(posedge clock) disable iff (rst)
      (reg_rd && reg_addr == `KPU_ADDR_EMPTY_SCAN_REPEATS) |=> reg_rdata[15:6] == 10'h000;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits not zero");
endmodule
`default_nettype wire

// ===== rtl/kpu_dummy_end.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== verif/kpu_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// key matrix, returns pulled down
// ****************************************
module kpu_key_matrix (
  input wire logic [7:0] scan_column_out,
  input wire logic [7:0] scan_column_oe_n,
  input wire logic [63:0] keys,
  output logic [7:0] return_line_in
);
  always_comb begin
    return_line_in = 8'h00;
    for (int c = 0; c < 8; c++) begin
      if (!scan_column_oe_n[c] && scan_column_out[c]) begin
        return_line_in = return_line_in | keys[c*8 +: 8];
      end
    end
  end
endmodule
// ****************************************
// dma controller, one ack per request
// ****************************************
module kpu_dma_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic dma_req,
  input wire logic ack_en,
  input wire logic page,
  output logic dma_ack,
  output logic dma_page_in
);
  always_ff @(posedge clock) begin
    if (rst) begin
      dma_ack <= 1'b0;
      dma_page_in <= 1'b0;
    end else begin
      dma_ack <= dma_req && ack_en && !dma_ack;
      dma_page_in <= dma_req && ack_en && !dma_ack && page;
    end
  end
endmodule
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "kpu_defines.svh"
module testbench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [31:0] reg_addr = 32'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, d;
  logic [7:0] return_line_in, scan_column_out, scan_column_oe_n, prev_oe;
  logic dma_page_in, dma_ack, dma_req;
  logic [63:0] key_data_out;
  logic [63:0] keys = 64'h0;
  logic ack_en = 1'b0;
  logic page = 1'b0;
  int errors = 0;
  int checks_done = 0;
  int gap = 0;
  int last_col = 0;
  int col, scans;
  localparam int tick = 750;
  always #20 clock = ~clock;
  kpu_top kpu_top_inst (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .return_line_in(return_line_in), .scan_column_out(scan_column_out),
    .scan_column_oe_n(scan_column_oe_n), .dma_page_in(dma_page_in),
    .dma_ack(dma_ack), .dma_req(dma_req), .key_data_out(key_data_out));
  kpu_key_matrix kpu_key_matrix_inst (.scan_column_out(scan_column_out),
    .scan_column_oe_n(scan_column_oe_n), .keys(keys), .return_line_in(return_line_in));
  kpu_dma_model kpu_dma_model_inst (.clock(clock), .rst(rst), .dma_req(dma_req),
    .ack_en(ack_en), .page(page), .dma_ack(dma_ack), .dma_page_in(dma_page_in));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [15:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [15:0] e);
    rd(a, d);
    check(d, e);
  endtask
  task automatic wait_data(input logic [63:0] v);
    int i;
    i = 0;
    while (key_data_out !== v && i < 25000) begin
      @(negedge clock);
      i++;
    end
    check(i < 25000, 1'b1);
  endtask
  task automatic wait_stop;
    int i;
    i = 0;
    d = 16'h1;
    while (d[0] !== 1'b0 && i < 20000) begin
      rd(`KPU_ADDR_CTRL, d);
      i++;
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ****************************************
  // column gap monitor
  // ****************************************
  always @(negedge clock) begin
    if (rst) begin
      last_col = 0;
      scans = 0;
    end else if (prev_oe == 8'hff && $countones(~scan_column_oe_n) == 1) begin
      for (int c = 0; c < 8; c++) begin
        if (!scan_column_oe_n[c]) begin
          col = c;
        end
      end
      if (col == 0) begin
        scans++;
      end
      if (col != 0 && col == last_col + 1) begin
        check(gap >= 2 * tick - 2 && gap <= 2 * tick + 2, 1'b1);
      end
      if (col == 0 && last_col == 7) begin
        check(gap >= 3 * tick - 2 && gap <= 3 * tick + 2, 1'b1);
      end
      check(scan_column_out, 64'h1 << col);
      last_col = col;
    end
    gap = (scan_column_oe_n == 8'hff) ? gap + 1 : 0;
    prev_oe = scan_column_oe_n;
  end
  initial begin
    repeat (95000) @(posedge clock);
    errors++;
    print_verdict;
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rdchk(`KPU_ADDR_WAIT, 16'h0000);
    rdchk(`KPU_ADDR_EMPTY_SCAN_REPEATS, 16'h0000);
    rdchk(`KPU_ADDR_FLAGS, 16'h0000);
    rdchk(`KPU_ADDR_CTRL, 16'h0000);
    rdchk(`KPU_ADDR_IDLE, 16'h001f);
    rdchk(32'h0b000100, 16'h0000);
    wr(`KPU_ADDR_WAIT, 16'hffff);
    rdchk(`KPU_ADDR_WAIT, 16'h03ff);
    wr(`KPU_ADDR_EMPTY_SCAN_REPEATS, 16'hffc2);
    rdchk(`KPU_ADDR_EMPTY_SCAN_REPEATS, 16'h0002);
    $display("test registers done");
    wr(`KPU_ADDR_WAIT, 16'h0001);
    wr(`KPU_ADDR_IDLE, 16'h0001);
    keys <= 64'h0000000000200000;
    ack_en <= 1'b1;
    page <= 1'b1;
    wr(`KPU_ADDR_CTRL, 16'h000d);
    wait_data(64'h0000000000200000);
    keys <= 64'h0;
    repeat (20) @(posedge clock);
    rdchk(`KPU_ADDR_FLAGS, 16'h000b);
    wait_data(64'h0);
    repeat (2) @(negedge clock);
    check(dma_req, 1'b0);
    wait_stop;
    check(scans, 3);
    rdchk(`KPU_ADDR_CTRL, 16'h000c);
    rdchk(`KPU_ADDR_FLAGS, 16'h000f);
    $display("test scans done");
    wr(`KPU_ADDR_FLAGS, 16'h0000);
    rdchk(`KPU_ADDR_FLAGS, 16'h000f);
    wr(`KPU_ADDR_FLAGS, 16'h0008);
    repeat (20) @(posedge clock);
    rdchk(`KPU_ADDR_FLAGS, 16'h0017);
    wr(`KPU_ADDR_FLAGS, 16'h001f);
    rdchk(`KPU_ADDR_FLAGS, 16'h0000);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rdchk(`KPU_ADDR_IDLE, 16'h001f);
    $display("test flags done");
    wr(`KPU_ADDR_IDLE, 16'h0001);
    keys <= 64'h1;
    wr(`KPU_ADDR_CTRL, 16'h0003);
    repeat (3 * tick) @(posedge clock);
    rd(`KPU_ADDR_CTRL, d);
    check(d[6:4] == 3'h2 || d[6:4] == 3'h3, 1'b1);
    rdchk(`KPU_ADDR_FLAGS, 16'h0001);
    $display("test auto scan done");
    print_verdict;
  end
endmodule
`default_nettype wire
